// ===== logic/rotate_shift_store_exec.sv
/*
 * apb-programmed execution block: rotates, shifts, system call entry, stores.
 * assumes a single pclk domain and a memory port that pulses ready for one cycle per store.
 */
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// RULE1: rotate-and-mask rotates left by the low five index bits only.
// RULE2: mask ones from begin through end, and with rotation, write result.
// RULE3: record bit set updates condition field zero; clear leaves it alone.
// RULE4: flags compare signed result with zero; summary overflow copied from exception reg.
// RULE5: left shift, index bit 26 clear: shift by bits 27-31, zero fill.
// RULE6: left shift, index bit 26 set: result is all zeros.
// RULE7: algebraic right shift, bit 26 clear: shift by 27-31, sign fill.
// RULE8: algebraic right shift, bit 26 set: all bits copy the sign.
// RULE9: carry set only for negative source losing a one bit; else cleared.
// RULE10: immediate algebraic shift uses the count field, same carry behaviour.
// RULE11: logical right shift by low six index bits, zero fill.
// RULE12: system call saves current address plus four to save pc register.
// RULE13: system call copies state bits 16-23, 25-27, 30-31 into save state.
// RULE14: save state bits 1-4 and 10-15 may hold any value.
// RULE15: system call vectors to offset 0xc00 from base picked by prefix bit.
// RULE16: system call is context synchronizing with earlier and later work.
// RULE17: byte store address is base-or-zero plus displacement or index.
// RULE18: update forms write address back to base; base zero is invalid.
// RULE19: double store writes the float source register unchanged.
module rotate_shift_store_exec #(
    parameter logic [31:0] HI_VEC_BASE = 32'hfff00000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic store_valid,
    input wire logic store_ready,
    output logic [31:0] store_addr,
    output logic [63:0] store_data,
    output logic store_dbl
);
    typedef enum logic [1:0] {st_idle, st_exec, st_store} state_t;
    localparam int STATUS_W_L = rss_pkg::STATUS_W;
    state_t state_ff;
    logic [31:0] cmd_ff;
    logic [31:0] src_ff;
    logic [31:0] index_ff;
    logic [31:0] base_ff;
    logic [15:0] disp_ff;
    logic [31:0] fhi_ff;
    logic [31:0] flo_ff;
    logic [31:0] machine_state_reg_ff;
    logic [31:0] current_instr_addr_ff;
    logic [31:0] fixed_point_exception_reg_ff;
    logic [31:0] result_ff;
    logic [3:0] cond_ff;
    logic [31:0] save_restore_pc_ff;
    logic [31:0] save_restore_state_ff;
    logic [31:0] nia_ff;
    logic [STATUS_W_L-1:0] status_ff;
    logic [STATUS_W_L-1:0] mask_ff;
    logic [31:0] prdata_ff;
    logic [31:0] store_addr_ff;
    logic [63:0] store_data_ff;
    logic store_dbl_ff;

    logic wr_en;
    logic rd_access;
    logic rd_setup;
    logic mapped;
    logic [31:0] rd_val;
    logic cmd_go;
    logic is_store;
    logic bad_form;
    logic exec;
    logic [STATUS_W_L-1:0] ev_set;
    logic [STATUS_W_L-1:0] ev_clr;
    rss_pkg::op_t cur_op;

    operand_if opd();

    ////////////////////////////////////////////////////////////////////////
    // apb slave: zero-wait access, read data captured in the setup cycle

    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_access = psel & penable & ~pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_ff;

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0;
        unique case (paddr)
            rss_pkg::CMD_OFF: rd_val = cmd_ff;
            rss_pkg::SRC_OFF: rd_val = src_ff;
            rss_pkg::INDEX_OFF: rd_val = index_ff;
            rss_pkg::BASE_OFF: rd_val = base_ff;
            rss_pkg::DISP_OFF: rd_val = {16'h0, disp_ff};
            rss_pkg::FHI_OFF: rd_val = fhi_ff;
            rss_pkg::FLO_OFF: rd_val = flo_ff;
            rss_pkg::MSTATE_OFF: rd_val = machine_state_reg_ff;
            rss_pkg::CUR_ADDR_OFF: rd_val = current_instr_addr_ff;
            rss_pkg::FXEXC_OFF: rd_val = fixed_point_exception_reg_ff;
            rss_pkg::RESULT_OFF: rd_val = result_ff;
            rss_pkg::COND_OFF: begin
                rd_val = {28'h0, cond_ff};
                rd_val[rss_pkg::COND_BUSY_BIT] = (state_ff != st_idle);
            end
            rss_pkg::SPC_OFF: rd_val = save_restore_pc_ff;
            rss_pkg::SSTATE_OFF: rd_val = save_restore_state_ff;
            rss_pkg::NIA_OFF: rd_val = nia_ff;
            rss_pkg::STATUS_OFF: rd_val = {28'h0, status_ff};
            rss_pkg::MASK_OFF: rd_val = {28'h0, mask_ff};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= rss_pkg::RST_WORD;
        end else if (rd_setup) begin
            prdata_ff <= rd_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operand registers; hardware write-back wins over a same-cycle apb write

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_ff <= rss_pkg::RST_WORD;
            index_ff <= rss_pkg::RST_WORD;
            disp_ff <= 16'h0;
            fhi_ff <= rss_pkg::RST_WORD;
            flo_ff <= rss_pkg::RST_WORD;
            current_instr_addr_ff <= rss_pkg::RST_WORD;
            mask_ff <= '0;
        end else if (wr_en) begin
            unique case (paddr)
                rss_pkg::SRC_OFF: src_ff <= pwdata;
                rss_pkg::INDEX_OFF: index_ff <= pwdata;
                rss_pkg::DISP_OFF: disp_ff <= pwdata[15:0];
                rss_pkg::FHI_OFF: fhi_ff <= pwdata;
                rss_pkg::FLO_OFF: flo_ff <= pwdata;
                rss_pkg::CUR_ADDR_OFF: current_instr_addr_ff <= pwdata;
                rss_pkg::MASK_OFF: mask_ff <= pwdata[STATUS_W_L-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_ff <= rss_pkg::RST_WORD;
        end else if (exec && is_store && cmd_ff[rss_pkg::CMD_UPD_BIT] && !bad_form) begin
            base_ff <= opd.effective_addr; // RULE18
        end else if (wr_en && paddr == rss_pkg::BASE_OFF) begin
            base_ff <= pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command sequencing: one operation at a time, commands ignored while busy

    assign cmd_go = wr_en && paddr == rss_pkg::CMD_OFF && state_ff == st_idle; // RULE16
    assign exec = (state_ff == st_exec);
    assign cur_op = rss_pkg::op_t'(cmd_ff[3:0]);
    assign is_store = (cur_op == rss_pkg::op_st_byte) || (cur_op == rss_pkg::op_st_dbl);
    assign bad_form = is_store && cmd_ff[rss_pkg::CMD_UPD_BIT] && cmd_ff[rss_pkg::CMD_BZ_BIT]; // RULE18

    assign opd.op = cur_op;
    assign opd.src = src_ff;
    assign opd.index = index_ff;
    assign opd.base = base_ff;
    assign opd.disp = disp_ff;
    assign opd.mb = cmd_ff[rss_pkg::CMD_MB_LSB +: 5];
    assign opd.me = cmd_ff[rss_pkg::CMD_ME_LSB +: 5];
    assign opd.sh = cmd_ff[rss_pkg::CMD_SH_LSB +: 5];
    assign opd.indexed = cmd_ff[rss_pkg::CMD_IDX_BIT];
    assign opd.update = cmd_ff[rss_pkg::CMD_UPD_BIT];
    assign opd.base_zero = cmd_ff[rss_pkg::CMD_BZ_BIT];

    shift_unit u_shift (
        .opd(opd.alu)
    );
    store_agu u_agu (
        .opd(opd.agu)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff <= rss_pkg::RST_WORD;
        end else if (cmd_go) begin
            cmd_ff <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= st_idle;
        end else begin
            unique case (state_ff)
                st_idle: if (cmd_go) state_ff <= st_exec;
                st_exec: state_ff <= (is_store && !bad_form) ? st_store : st_idle;
                st_store: if (store_ready) state_ff <= st_idle;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // arithmetic results and condition field

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_ff <= rss_pkg::RST_WORD;
            cond_ff <= 4'h0;
        end else if (exec && cur_op <= rss_pkg::op_shr) begin
            result_ff <= opd.res;
            if (cmd_ff[rss_pkg::CMD_REC_BIT]) begin // RULE3
                cond_ff <= {$signed(opd.res) < 0, $signed(opd.res) > 0, // RULE4
                    opd.res == 32'h0, fixed_point_exception_reg_ff[rss_pkg::FXEXC_SO_BIT]}; // RULE4
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fixed_point_exception_reg_ff <= rss_pkg::RST_WORD;
        end else if (exec && (cur_op == rss_pkg::op_shra || cur_op == rss_pkg::op_shra_imm)) begin
            fixed_point_exception_reg_ff[rss_pkg::FXEXC_CY_BIT] <= opd.cy; // RULE9 RULE10
        end else if (wr_en && paddr == rss_pkg::FXEXC_OFF) begin
            fixed_point_exception_reg_ff <= pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // system call entry; earlier stores have drained since commands wait for idle

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            save_restore_pc_ff <= rss_pkg::RST_WORD;
            save_restore_state_ff <= rss_pkg::RST_WORD;
            nia_ff <= rss_pkg::RST_WORD;
        end else if (exec && cur_op == rss_pkg::op_syscall) begin // RULE16
            save_restore_pc_ff <= current_instr_addr_ff + rss_pkg::SYSCALL_STEP; // RULE12
            // unsaved positions, including the undefined ones, read zero
            save_restore_state_ff <= machine_state_reg_ff & rss_pkg::SAVE_MASK; // RULE13 RULE14
            nia_ff <= (machine_state_reg_ff[rss_pkg::IP_BIT] ? HI_VEC_BASE : 32'h0)
                | rss_pkg::SYSCALL_VEC; // RULE15
        end
    end

    // new state keeps only the vector prefix; later commands see it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            machine_state_reg_ff <= rss_pkg::RST_WORD;
        end else if (exec && cur_op == rss_pkg::op_syscall) begin
            machine_state_reg_ff <= machine_state_reg_ff & (32'h1 << rss_pkg::IP_BIT); // RULE15
        end else if (wr_en && paddr == rss_pkg::MSTATE_OFF) begin
            machine_state_reg_ff <= pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // store request towards memory, held until accepted

    assign store_valid = (state_ff == st_store);
    assign store_addr = store_addr_ff;
    assign store_data = store_data_ff;
    assign store_dbl = store_dbl_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store_addr_ff <= rss_pkg::RST_WORD;
            store_data_ff <= 64'h0;
            store_dbl_ff <= 1'b0;
        end else if (exec && is_store && !bad_form) begin
            store_addr_ff <= opd.effective_addr; // RULE17
            store_dbl_ff <= (cur_op == rss_pkg::op_st_dbl);
            if (cur_op == rss_pkg::op_st_dbl) begin
                store_data_ff <= {fhi_ff, flo_ff}; // RULE19
            end else begin
                store_data_ff <= {56'h0, src_ff[7:0]}; // RULE17
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky events, cleared by reading; a new event beats the clear

    always_comb begin
        ev_set = '0;
        ev_set[rss_pkg::ST_DONE] = (exec && !(is_store && !bad_form))
            || (store_valid && store_ready);
        ev_set[rss_pkg::ST_STORE] = store_valid && store_ready;
        ev_set[rss_pkg::ST_SYSCALL] = exec && cur_op == rss_pkg::op_syscall;
        ev_set[rss_pkg::ST_INVALID] = exec && bad_form;
        ev_clr = (rd_access && paddr == rss_pkg::STATUS_OFF) ? '1 : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= '0;
        end else begin
            status_ff <= (status_ff & ~ev_clr) | ev_set;
        end
    end

    assign irq = |(status_ff & mask_ff);
    ////////////////////////////////////////////////////////////////////////
    // checks

    a_store_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
        store_valid && !store_ready |=> store_valid && $stable(store_addr)
            && $stable(store_data))
        else $error("store request not held");

    a_byte_store_data: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
        exec && cur_op == rss_pkg::op_st_byte && !bad_form
            |=> store_valid && !store_dbl && store_data == {56'h0, $past(src_ff[7:0])})
        else $error("byte store data wrong");

    a_dbl_store_data: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
        exec && cur_op == rss_pkg::op_st_dbl && !bad_form
            |=> store_valid && store_dbl && store_data == {$past(fhi_ff), $past(flo_ff)})
        else $error("double store data wrong");

    a_syscall_pc: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        exec && cur_op == rss_pkg::op_syscall
            |=> save_restore_pc_ff == $past(current_instr_addr_ff) + 32'h4)
        else $error("save pc wrong");

    a_syscall_state: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
        exec && cur_op == rss_pkg::op_syscall |=> ((save_restore_state_ff
            ^ $past(machine_state_reg_ff)) & rss_pkg::SAVE_MASK) == '0)
        else $error("saved state wrong");

    a_syscall_vector: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
        exec && cur_op == rss_pkg::op_syscall |=> nia_ff[19:0] == 20'h00c00
            && ev_set == '0 ##0 status_ff[rss_pkg::ST_SYSCALL])
        else $error("system call vector or event wrong");

    a_no_record: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        !(exec && cmd_ff[rss_pkg::CMD_REC_BIT]) |=> $stable(cond_ff))
        else $error("condition field changed without record bit");

    a_zero_shift_cy: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        exec && cur_op == rss_pkg::op_shra && index_ff[5:0] == 6'h0
            |=> !fixed_point_exception_reg_ff[rss_pkg::FXEXC_CY_BIT] && result_ff == $past(src_ff))
        else $error("zero algebraic shift changed value or set carry");

    a_update_base: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
        exec && is_store && cmd_ff[rss_pkg::CMD_UPD_BIT] && !bad_form
            |=> base_ff == $past(opd.effective_addr) ##1 !exec)
        else $error("update form did not write address to base");

    c_syscall: cover property (@(posedge pclk) disable iff (!presetn)
        exec && cur_op == rss_pkg::op_syscall);
    c_store_stall: cover property (@(posedge pclk) disable iff (!presetn)
        store_valid && !store_ready ##1 store_valid && store_ready);
    c_carry_set: cover property (@(posedge pclk) disable iff (!presetn)
        exec && cur_op == rss_pkg::op_shra_imm && opd.cy);
endmodule

// ===== logic/rss_pkg.sv
/*
 * constants, field layout and operation codes shared by the execution block.
 * assumes bit 0 of every register is the least significant bit.
 */
package rss_pkg;
    localparam logic [7:0] CMD_OFF = 8'h00, SRC_OFF = 8'h04, INDEX_OFF = 8'h08, BASE_OFF = 8'h0c,
        DISP_OFF = 8'h10, FHI_OFF = 8'h14, FLO_OFF = 8'h18, MSTATE_OFF = 8'h1c,
        CUR_ADDR_OFF = 8'h20, FXEXC_OFF = 8'h24, RESULT_OFF = 8'h28, COND_OFF = 8'h2c,
        SPC_OFF = 8'h30, SSTATE_OFF = 8'h34, NIA_OFF = 8'h38, STATUS_OFF = 8'h3c,
        MASK_OFF = 8'h40;
    // command word fields
    localparam int CMD_REC_BIT = 4, CMD_MB_LSB = 5, CMD_ME_LSB = 10, CMD_SH_LSB = 15;
    localparam int CMD_IDX_BIT = 20, CMD_UPD_BIT = 21, CMD_BZ_BIT = 22, COND_BUSY_BIT = 8;
    // status bits
    localparam int STATUS_W = 4, ST_DONE = 0, ST_STORE = 1, ST_SYSCALL = 2, ST_INVALID = 3;
    // machine state fields saved on a system call
    localparam logic [31:0] SAVE_MASK = 32'h0000ff73;
    localparam int IP_BIT = 6, FXEXC_SO_BIT = 31, FXEXC_CY_BIT = 29;
    localparam logic [31:0] SYSCALL_STEP = 32'h00000004;
    localparam logic [31:0] SYSCALL_VEC = 32'h00000c00;
    localparam logic [31:0] RST_WORD = 32'h00000000;
    typedef enum logic [3:0] {
        op_rot_mask, op_shl, op_shra, op_shra_imm, op_shr,
        op_syscall, op_st_byte, op_st_dbl
    } op_t;
endpackage

// ===== logic/operand_if.sv
/*
 * operand and result bundle between the controller and its two units.
 * assumes the controller drives every operand from flip-flops.
 */
`timescale 1ns/100ps
interface operand_if;
    rss_pkg::op_t op;
    logic [31:0] src;
    logic [31:0] index;
    logic [31:0] base;
    logic [15:0] disp;
    logic [4:0] mb;
    logic [4:0] me;
    logic [4:0] sh;
    logic indexed;
    logic update;
    logic base_zero;
    logic [31:0] res;
    logic cy;
    logic [31:0] effective_addr;
    modport ctrl(output op, src, index, base, disp, mb, me, sh, indexed, update,
        base_zero, input res, cy, effective_addr);
    modport alu(input op, src, index, mb, me, sh, output res, cy);
    modport agu(input base, index, disp, indexed, update, base_zero, output effective_addr);
endinterface

// ===== logic/shift_unit.sv
/*
 * combinational rotate, mask and shift datapath.
 * assumes operands are stable for the cycle in which the result is taken.
 */
`timescale 1ns/100ps
module shift_unit (
    operand_if.alu opd
);
    logic [63:0] rot64;
    logic [31:0] rot;
    logic [31:0] mask;
    logic [5:0] amt;
    logic [63:0] lost64;
    int bi;

    always_comb begin
        bi = 0;
        rot64 = {opd.src, opd.src} << opd.index[4:0]; // RULE1
        rot = rot64[63:32];
        for (int i = 0; i < 32; i++) begin
            bi = 31 - i;
            // a begin past the end wraps around bit 31
            if (opd.mb <= opd.me) begin
                mask[i] = (bi >= int'(opd.mb)) && (bi <= int'(opd.me)); // RULE2
            end else begin
                mask[i] = (bi >= int'(opd.mb)) || (bi <= int'(opd.me)); // RULE2
            end
        end
        if (opd.op == rss_pkg::op_shra_imm) begin
            amt = {1'b0, opd.sh}; // RULE10
        end else begin
            amt = opd.index[5] ? 6'h20 : {1'b0, opd.index[4:0]};
        end
        lost64 = {opd.src, 32'h0} >> amt;
        opd.cy = 1'b0;
        unique case (opd.op)
            rss_pkg::op_rot_mask: opd.res = rot & mask; // RULE2
            rss_pkg::op_shl: begin
                opd.res = opd.index[5] ? 32'h0 : opd.src << opd.index[4:0]; // RULE5 RULE6
            end
            rss_pkg::op_shra, rss_pkg::op_shra_imm: begin
                opd.res = 32'($signed(opd.src) >>> amt); // RULE7 RULE8 RULE10
                opd.cy = opd.src[31] & (|lost64[31:0]); // RULE9
            end
            rss_pkg::op_shr: opd.res = opd.src >> opd.index[5:0]; // RULE11
            default: opd.res = 32'h0;
        endcase
    end
endmodule

// ===== logic/store_agu.sv
/*
 * effective address adder for the byte and double-word stores.
 * assumes base_zero is set by software when the base field is zero.
 */
`timescale 1ns/100ps
module store_agu (
    operand_if.agu opd
);
    logic [31:0] b;
    logic [31:0] off;

    always_comb begin
        b = (opd.base_zero && !opd.update) ? 32'h0 : opd.base; // RULE17
        off = opd.indexed ? opd.index : {{16{opd.disp[15]}}, opd.disp}; // RULE17
        opd.effective_addr = b + off; // RULE17
    end
endmodule

// ===== sim/store_mem_model.sv
/*
 memory side model: takes byte and double stores after a set stall.
 assumes the block holds its store request until ready is seen.
*/
`timescale 1ns/100ps
module store_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] stall,
    input wire logic store_valid,
    output logic store_ready,
    input wire logic [31:0] store_addr,
    input wire logic [63:0] store_data,
    input wire logic store_dbl,
    output logic [31:0] got_addr,
    output logic [63:0] got_data,
    output logic got_dbl,
    output logic [7:0] got_cnt
);
    logic [3:0] wait_ff;
    ////////////////////////////////////////////////////////////
    // ready is a single pulse, so a held request is taken exactly once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store_ready <= 1'b0;
            wait_ff <= 4'h0;
            got_addr <= 32'h0;
            got_data <= 64'h0;
            got_dbl <= 1'b0;
            got_cnt <= 8'h00;
        end else if (store_ready) begin
            store_ready <= 1'b0;
            wait_ff <= 4'h0;
            got_addr <= store_addr;
            got_data <= store_data;
            got_dbl <= store_dbl;
            got_cnt <= got_cnt + 8'h01;
        end else if (store_valid && wait_ff == stall) begin
            store_ready <= 1'b1;
        end else if (store_valid) begin
            wait_ff <= wait_ff + 4'h1;
        end
    end
endmodule

// ===== sim/rotate_shift_store_exec_tb.sv
/*
 bench: apb checks of rotates, shifts, system call, stores.
 assumes store_mem_model answers stores.
*/
`timescale 1ns/100ps
module rotate_shift_store_exec_tb;
    localparam logic [31:0] VB = 32'h0010_0000;
    localparam logic [31:0] S = 32'hf000_0031;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, got_cnt, n;
    logic [31:0] pwdata = 32'h0, prdata, store_addr, got_addr, q, ms;
    logic [63:0] store_data, got_data;
    logic [3:0] stall = 4'h0, lcf = 4'h0;
    logic pready, pslverr, irq, store_valid, store_ready, store_dbl, got_dbl, err_q;
    int error_cnt = 0, tests_run = 0;
    rotate_shift_store_exec #(.HI_VEC_BASE(VB)) rotate_shift_store_exec_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .store_valid(store_valid), .store_ready(store_ready), .store_addr(store_addr),
        .store_data(store_data), .store_dbl(store_dbl));
    store_mem_model store_mem_model_i (.pclk(pclk), .presetn(presetn), .stall(stall),
        .store_valid(store_valid), .store_ready(store_ready), .store_addr(store_addr),
        .store_data(store_data), .store_dbl(store_dbl), .got_addr(got_addr),
        .got_data(got_data), .got_dbl(got_dbl), .got_cnt(got_cnt));
    initial forever #10 pclk = ~pclk;
    ////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic chk(input logic [31:0] g, e);
        tests_run++;
        if (g !== e) begin
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
            error_cnt++;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r & m, e & m);
    endtask
    task automatic run(input logic [31:0] c);
        logic [31:0] r;
        wr(rss_pkg::CMD_OFF, c);
        do apb(1'b0, rss_pkg::COND_OFF, 32'h0, r); while (r[rss_pkg::COND_BUSY_BIT] !== 1'b0);
    endtask
    function automatic logic [31:0] mk(input int op, rec, mb, me, sh, f);
        return {9'h0, f[2:0], sh[4:0], me[4:0], mb[4:0], rec[0], op[3:0]};
    endfunction
    function automatic logic [31:0] msk(input int b, e);
        logic [31:0] m;
        for (int i = 0; i < 32; i++) m[31 - i] = (b <= e) ? (i >= b && i <= e) : (i >= b || i <= e);
        return m;
    endfunction
    task automatic shc(input logic [31:0] c, s, x, r, input int cy);
        wr(rss_pkg::SRC_OFF, s);
        wr(rss_pkg::INDEX_OFF, x);
        run(c);
        if (c[4]) lcf = {r[31], !r[31] && r != 32'h0, r == 32'h0, 1'b1};
        rd(rss_pkg::RESULT_OFF, r, '1);
        rd(rss_pkg::COND_OFF, {28'h0, lcf}, 32'h0000_000f);
        if (c[3:0] inside {4'h2, 4'h3}) rd(rss_pkg::FXEXC_OFF, {2'b0, cy[0], 29'h0}, 32'h2000_0000);
    endtask
    task automatic stc(input logic [31:0] c, a, input logic [63:0] d, input int b);
        n = got_cnt;
        run(c);
        rd(rss_pkg::STATUS_OFF, 32'h3, 32'hf);
        chk(got_addr, a);
        chk(got_data[63:32], d[63:32]);
        chk(got_data[31:0], d[31:0]);
        chk({31'h0, got_dbl}, {31'h0, b[0]});
        chk({24'h0, got_cnt}, {24'h0, n + 8'h01});
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(rss_pkg::RESULT_OFF, 32'h0, '1);
        apb(1'b0, 8'h44, 32'h0, q);
        chk(q, 32'h0);
        chk(32'(err_q), 32'h1);
        wr(rss_pkg::FXEXC_OFF, 32'h8000_0000);
        shc(mk(0, 1, 20, 3, 0, 0), S, 32'hffff_ffe4, ((S << 4) | (S >> 28)) & msk(20, 3), 0);
        shc(mk(0, 0, 4, 27, 0, 0), S, 32'h1f, ((S << 31) | (S >> 1)) & msk(4, 27), 0);
        shc(mk(1, 1, 0, 0, 0, 0), S, 32'hffff_ffc3, S << 3, 0);
        shc(mk(1, 1, 0, 0, 0, 0), S, 32'h20, 32'h0, 0);
        shc(mk(2, 1, 0, 0, 0, 0), S, 32'h4, 32'hff00_0003, 1);
        shc(mk(2, 0, 0, 0, 0, 0), S, 32'h25, 32'hffff_ffff, 1);
        shc(mk(2, 1, 0, 0, 0, 0), S, 32'h0, S, 0);
        shc(mk(2, 1, 0, 0, 0, 0), 32'h31, 32'h4, 32'h3, 0);
        shc(mk(3, 1, 0, 0, 5, 0), S, 32'h0, 32'hff80_0001, 1);
        shc(mk(4, 1, 0, 0, 0, 0), S, 32'h43, 32'h1e00_0006, 0);
        shc(mk(4, 1, 0, 0, 0, 0), S, 32'h20, 32'h0, 0);
        wr(rss_pkg::MASK_OFF, 32'h4);
        @(negedge pclk) chk(32'(irq), 32'h0);
        rd(rss_pkg::STATUS_OFF, 32'h1, 32'hf);
        for (int i = 0; i < 2; i++) begin
            ms = i ? 32'h1234_ff40 : 32'hedcb_00b3;
            wr(rss_pkg::MSTATE_OFF, ms);
            wr(rss_pkg::CUR_ADDR_OFF, 32'h1000 + 32'(i * 16));
            run(mk(5, 0, 0, 0, 0, 0));
            rd(rss_pkg::SPC_OFF, 32'h1004 + 32'(i * 16), '1);
            rd(rss_pkg::SSTATE_OFF, ms, rss_pkg::SAVE_MASK);
            rd(rss_pkg::NIA_OFF, (i ? VB : 32'h0) + rss_pkg::SYSCALL_VEC, '1);
            @(negedge pclk) chk(32'(irq), 32'h1);
            rd(rss_pkg::STATUS_OFF, 32'h5, 32'hf);
            @(negedge pclk) chk(32'(irq), 32'h0);
        end
        wr(rss_pkg::SRC_OFF, 32'h1122_3344);
        wr(rss_pkg::BASE_OFF, 32'h1234);
        wr(rss_pkg::DISP_OFF, 32'hfff0);
        stc(mk(6, 0, 0, 0, 0, 4), 32'hffff_fff0, 64'h44, 0);
        wr(rss_pkg::INDEX_OFF, 32'h24);
        wr(rss_pkg::BASE_OFF, 32'h1000);
        stall <= 4'h3;
        stc(mk(6, 0, 0, 0, 0, 3), 32'h1024, 64'h44, 0);
        rd(rss_pkg::BASE_OFF, 32'h1024, '1);
        wr(rss_pkg::FHI_OFF, 32'h89ab_cdef);
        wr(rss_pkg::FLO_OFF, 32'h0123_4567);
        wr(rss_pkg::DISP_OFF, 32'h8);
        stc(mk(7, 0, 0, 0, 0, 2), 32'h102c, 64'h89ab_cdef_0123_4567, 1);
        n = got_cnt;
        run(mk(7, 0, 0, 0, 0, 6));
        rd(rss_pkg::STATUS_OFF, 32'h9, 32'hf);
        chk({24'h0, got_cnt}, {24'h0, n});
        rd(rss_pkg::BASE_OFF, 32'h102c, '1);
        complete_run();
    end
endmodule
